// [hdl/aib_bridge.sv]
// Analog interface bus bridge: arbiter, trigger routing, converters
//
// What this block does
// - Converter results may be read by the CPU and DMA of both sides.
// - All other analog registers are reachable only by the control CPU, except the master status word, read only by the master CPU.
// - Control CPU and control DMA enter on separate request ports.
// - One arbiter serves a single bus cycle at a time from all sides.
// - Control-side start sources are routed onto eight shared triggers.
// - Same-numbered end flags of both converters are ANDed to interrupts.
// - All eight interrupts go to the expander, four also to control DMA.
// - Each converter stores a 12-bit value of its channel as a result.
// - Sixteen channels per converter, low eight on unit A, high on B.
// - A simultaneous request samples one channel on A and one on B at once.
// - Pending requests in a converter are converted one after another.
// - A conversion starts only on a trigger from the control side.
// - End of conversion is flagged only once its results are stored.
// - Eight select registers each choose one of 22 start sources.
// - Up to four pending bus cycles are held by the arbiter at once.
// - Each side has a status word: power, clock, bus, trigger, interrupt.
`timescale 1ns/1ns
`default_nettype none
module aib_bridge
    import aib_pkg::*;
(
    input  wire logic                            clock,
    input  wire logic                            reset,
    input  wire aib_req_type [NUM_REQ-1:0]       bus_req,
    output aib_rsp_type [NUM_REQ-1:0]            bus_rsp,
    input  wire logic [NUM_SRC-1:0]              soc_source,
    input  wire logic [NUM_CHAN-1:0][RES_W-1:0]  first_converter_level,
    input  wire logic [NUM_CHAN-1:0][RES_W-1:0]  second_converter_level,
    input  wire logic                            analog_powered,
    input  wire logic                            analog_system_clock,
    output logic [NUM_TRIG-1:0]                  master_eoc_irq,
    output logic [NUM_TRIG-1:0]                  peripheral_interrupt_expander,
    output logic [NUM_DMA_TRIG-1:0]              control_dma_trigger
);

    ////////////////////////////////////////////////////////////////////////
    // Access rights
    function automatic logic access_ok(input logic [1:0] who,
                                       input logic [ADDR_W-1:0] adr,
                                       input logic wr);
        logic is_result;
        logic is_ctrl;
        is_result = (adr < ADR_TRIG_SEL);
        is_ctrl   = (adr >= ADR_TRIG_SEL) && (adr <= ADR_CTRL_STATUS);
        if (is_result) begin
            access_ok = !wr;
        end else if (adr == ADR_MSTR_STATUS) begin
            access_ok = !wr && (who == REQ_MASTER_CPU);
        end else begin
            access_ok = is_ctrl && (who == REQ_CONTROL_CPU)
                        && !(wr && adr == ADR_CTRL_STATUS);
        end
    endfunction

    function automatic logic [1:0] rr_pick(input logic [NUM_REQ-1:0] pend,
                                           input logic [1:0] last);
        logic [1:0] idx;
        rr_pick = last;
        for (int i = NUM_REQ; i >= 1; i--) begin
            idx = last + 2'(i);
            if (pend[idx]) begin
                rr_pick = idx;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Storage
    aib_state_type                    state_ff;
    logic [1:0]                       owner_ff;
    logic [1:0]                       last_ff;
    logic                             ok_ff;
    logic [DATA_W-1:0]                rdata_ff;
    logic [NUM_TRIG-1:0][SEL_W-1:0]   sel_ff;
    logic [1:0][NUM_TRIG-1:0][CFG_W-1:0] cfg_ff;
    logic [1:0][NUM_CHAN-1:0][RES_W-1:0] result_ff;
    logic [1:0][NUM_TRIG-1:0]         pend_ff;
    logic [1:0][NUM_TRIG-1:0]         eoc_ff;
    logic [1:0]                       busy_ff;
    logic [1:0][2:0]                  cur_ff;
    logic [1:0][7:0]                  cnt_ff;
    logic [1:0][RES_W-1:0]            samp_a_ff;
    logic [1:0][RES_W-1:0]            samp_b_ff;
    logic [1:0]                       simul_ff;
    logic [1:0]                       onb_ff;
    logic [NUM_SRC-1:0]               src_ff;
    logic [NUM_TRIG-1:0]              and_ff;
    logic [2:0]                       aclk_sync_ff;
    logic [7:0]                       aclk_cnt_ff;
    logic [1:0]                       refused_ff;
    logic [1:0]                       overrun_ff;

    logic [NUM_REQ-1:0]               pending;
    logic [1:0]                       winner;
    aib_req_type                      cur_req;
    aib_req_type                      own_req;
    logic [DATA_W-1:0]                rd_value;
    logic [NUM_TRIG-1:0]              trig_fire;
    logic [NUM_SRC-1:0]               src_rise;
    logic                             clk_present;
    logic [DATA_W-1:0]                status_word;
    logic                             acc_ok;

    ////////////////////////////////////////////////////////////////////////
    // Arbiter
    always_comb begin
        for (int i = 0; i < NUM_REQ; i++) begin
            pending[i] = bus_req[i].valid;
        end
    end

    assign winner  = rr_pick(pending, last_ff);
    assign cur_req = bus_req[winner];
    assign own_req = bus_req[owner_ff];
    assign acc_ok  = access_ok(winner, cur_req.addr, cur_req.write);

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            owner_ff <= 2'h0;
            last_ff  <= 2'h3;
            ok_ff    <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (|pending) begin
                        state_ff <= ST_ACCESS;
                        owner_ff <= winner;
                        last_ff  <= winner;
                        ok_ff    <= acc_ok;
                        rdata_ff <= acc_ok ? rd_value : 16'h0000;
                    end
                end
                ST_ACCESS: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_REQ; i++) begin
            bus_rsp[i].done    = (state_ff == ST_ACCESS)
                                 && (owner_ff == 2'(i));
            bus_rsp[i].refused = bus_rsp[i].done && !ok_ff;
            bus_rsp[i].rdata   = rdata_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read decode
    always_comb begin
        logic [ADDR_W-1:0] a;
        a = cur_req.addr;
        rd_value = 16'h0000;
        if (a < ADR_RES2_BASE) begin
            rd_value = {4'h0, result_ff[0][a[3:0]]};
        end else if (a < ADR_TRIG_SEL) begin
            rd_value = {4'h0, result_ff[1][a[3:0]]};
        end else if (a < ADR_CFG1_BASE) begin
            rd_value = {11'h000, sel_ff[a[2:0]]};
        end else if (a < ADR_CFG2_BASE) begin
            rd_value = {11'h000, cfg_ff[0][a[2:0]]};
        end else if (a < ADR_CTRL_STATUS) begin
            rd_value = {11'h000, cfg_ff[1][a[2:0]]};
        end else begin
            rd_value = status_word;
        end
    end

    // Writes land in the access cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int k = 0; k < NUM_TRIG; k++) begin
                sel_ff[k]    <= SEL_RESET;
                cfg_ff[0][k] <= CFG_RESET;
                cfg_ff[1][k] <= CFG_RESET;
            end
        end else if (state_ff == ST_ACCESS && ok_ff && own_req.write) begin
            if (own_req.addr < ADR_CFG1_BASE) begin
                sel_ff[own_req.addr[2:0]] <= own_req.wdata[SEL_W-1:0];
            end else if (own_req.addr < ADR_CFG2_BASE) begin
                cfg_ff[0][own_req.addr[2:0]] <= own_req.wdata[CFG_W-1:0];
            end else begin
                cfg_ff[1][own_req.addr[2:0]] <= own_req.wdata[CFG_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger routing
    always_ff @(posedge clock) begin
        if (reset) begin
            src_ff <= '0;
        end else begin
            src_ff <= soc_source;
        end
    end

    assign src_rise = soc_source & ~src_ff;

    always_comb begin
        for (int k = 0; k < NUM_TRIG; k++) begin
            trig_fire[k] = (sel_ff[k] < 5'(NUM_SRC))
                           && src_rise[sel_ff[k]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converters
    always_ff @(posedge clock) begin
        if (reset) begin
            pend_ff   <= '0;
            eoc_ff    <= '0;
            busy_ff   <= 2'b00;
            cur_ff    <= '0;
            cnt_ff    <= '0;
            samp_a_ff <= '0;
            samp_b_ff <= '0;
            simul_ff  <= 2'b00;
            onb_ff    <= 2'b00;
            result_ff <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                logic [3:0] ch;
                logic [2:0] nxt_k;
                logic       found;
                ch    = 4'h0;
                nxt_k = 3'h0;
                found = 1'b0;
                for (int k = NUM_TRIG - 1; k >= 0; k--) begin
                    if (pend_ff[c][k]) begin
                        nxt_k = 3'(k);
                        found = 1'b1;
                    end
                end
                ch = cfg_ff[c][nxt_k][CFG_CHAN_LSB +: 4];
                if (!busy_ff[c]) begin
                    if (found) begin
                        busy_ff[c]  <= 1'b1;
                        cur_ff[c]   <= nxt_k;
                        cnt_ff[c]   <= 8'(CONV_CYCLES);
                        simul_ff[c] <= cfg_ff[c][nxt_k][CFG_SIMUL_BIT];
                        onb_ff[c]   <= ch[3];
                        samp_a_ff[c] <= (c == 0)
                            ? first_converter_level[{1'b0, ch[2:0]}]
                            : second_converter_level[{1'b0, ch[2:0]}];
                        samp_b_ff[c] <= (c == 0)
                            ? first_converter_level[{1'b1, ch[2:0]}]
                            : second_converter_level[{1'b1, ch[2:0]}];
                        pend_ff[c][nxt_k] <= 1'b0;
                    end
                end else if (cnt_ff[c] == 8'h01) begin
                    busy_ff[c] <= 1'b0;
                    result_ff[c][{1'b0, cur_ff[c]}] <=
                        onb_ff[c] && !simul_ff[c]
                        ? samp_b_ff[c] : samp_a_ff[c];
                    if (simul_ff[c]) begin
                        result_ff[c][{1'b1, cur_ff[c]}] <= samp_b_ff[c];
                    end
                    eoc_ff[c][cur_ff[c]] <= 1'b1;
                end else begin
                    cnt_ff[c] <= cnt_ff[c] - 8'h01;
                end
                for (int k = 0; k < NUM_TRIG; k++) begin
                    if (trig_fire[k]) begin
                        pend_ff[c][k] <= 1'b1;
                        if (!(busy_ff[c] && cnt_ff[c] == 8'h01
                              && cur_ff[c] == 3'(k))) begin
                            eoc_ff[c][k] <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // End of conversion interrupts
    always_ff @(posedge clock) begin
        if (reset) begin
            and_ff                        <= '0;
            master_eoc_irq                <= '0;
            peripheral_interrupt_expander <= '0;
            control_dma_trigger           <= '0;
        end else begin
            and_ff <= eoc_ff[0] & eoc_ff[1];
            master_eoc_irq <= eoc_ff[0] & eoc_ff[1] & ~and_ff;
            peripheral_interrupt_expander <= eoc_ff[0] & eoc_ff[1]
                                             & ~and_ff;
            control_dma_trigger <= eoc_ff[0][NUM_DMA_TRIG-1:0]
                                   & eoc_ff[1][NUM_DMA_TRIG-1:0]
                                   & ~and_ff[NUM_DMA_TRIG-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link status
    always_ff @(posedge clock) begin
        if (reset) begin
            aclk_sync_ff <= 3'h0;
            aclk_cnt_ff  <= 8'h00;
        end else begin
            aclk_sync_ff <= {aclk_sync_ff[1:0], analog_system_clock};
            if (aclk_sync_ff[2] != aclk_sync_ff[1]) begin
                aclk_cnt_ff <= 8'h00;
            end else if (aclk_cnt_ff != 8'(CLK_LOSS_CYCLES)) begin
                aclk_cnt_ff <= aclk_cnt_ff + 8'h01;
            end
        end
    end

    assign clk_present = (aclk_cnt_ff != 8'(CLK_LOSS_CYCLES));

    // Sticky faults per side, index 0 master, 1 control; set wins
    always_ff @(posedge clock) begin
        if (reset) begin
            refused_ff <= 2'b00;
            overrun_ff <= 2'b00;
        end else begin
            for (int s = 0; s < 2; s++) begin
                logic rd_clr;
                logic ref_set;
                logic ovr_set;
                rd_clr  = (state_ff == ST_IDLE) && (|pending) && acc_ok
                          && !cur_req.write
                          && (cur_req.addr == (s == 1 ? ADR_CTRL_STATUS
                                                      : ADR_MSTR_STATUS));
                ref_set = (state_ff == ST_ACCESS) && !ok_ff
                          && (owner_ff[1] == 1'(s));
                ovr_set = |(trig_fire & (pend_ff[0] | pend_ff[1]));
                if (ref_set) begin
                    refused_ff[s] <= 1'b1;
                end else if (rd_clr) begin
                    refused_ff[s] <= 1'b0;
                end
                if (ovr_set) begin
                    overrun_ff[s] <= 1'b1;
                end else if (rd_clr) begin
                    overrun_ff[s] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        logic s;
        s = (cur_req.addr == ADR_CTRL_STATUS);
        status_word = 16'h0000;
        status_word[ST_POWER_BIT] = analog_powered;
        status_word[ST_CLOCK_BIT] = clk_present;
        status_word[ST_BUS_BIT]   = !refused_ff[s];
        status_word[ST_TRIG_BIT]  = !overrun_ff[s];
        status_word[ST_INT_BIT]   = clk_present && analog_powered;
    end

endmodule
`default_nettype wire

// [hdl/aib_pkg.sv]
// Constants and types of the analog interface bus bridge
package aib_pkg;

    localparam int CLK_PERIOD_NS  = 8;
    localparam int CONV_TIME_NS   = 350;
    localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int CLK_LOSS_NS    = 1000;
    localparam int CLK_LOSS_CYCLES = CLK_LOSS_NS / CLK_PERIOD_NS;

    localparam int NUM_REQ        = 4;
    localparam int NUM_TRIG       = 8;
    localparam int NUM_SRC        = 22;
    localparam int NUM_CHAN       = 16;
    localparam int NUM_DMA_TRIG   = 4;
    localparam int RES_W          = 12;
    localparam int ADDR_W         = 12;
    localparam int DATA_W         = 16;

    // Requester numbering
    localparam logic [1:0] REQ_MASTER_CPU  = 2'h0;
    localparam logic [1:0] REQ_MASTER_DMA  = 2'h1;
    localparam logic [1:0] REQ_CONTROL_CPU = 2'h2;
    localparam logic [1:0] REQ_CONTROL_DMA = 2'h3;

    // Word address map
    localparam logic [11:0] ADR_RES1_BASE   = 12'h000;
    localparam logic [11:0] ADR_RES2_BASE   = 12'h010;
    localparam logic [11:0] ADR_TRIG_SEL    = 12'h020;
    localparam logic [11:0] ADR_CFG1_BASE   = 12'h028;
    localparam logic [11:0] ADR_CFG2_BASE   = 12'h030;
    localparam logic [11:0] ADR_CTRL_STATUS = 12'h038;
    localparam logic [11:0] ADR_MSTR_STATUS = 12'h039;

    // Field layouts
    localparam int CFG_CHAN_LSB   = 0;
    localparam int CFG_SIMUL_BIT  = 4;
    localparam int SEL_W          = 5;
    localparam int CFG_W          = 5;
    localparam int ST_POWER_BIT   = 0;
    localparam int ST_CLOCK_BIT   = 1;
    localparam int ST_BUS_BIT     = 2;
    localparam int ST_TRIG_BIT    = 3;
    localparam int ST_INT_BIT     = 4;

    // Reset values
    localparam logic [4:0] SEL_RESET = 5'h1f;
    localparam logic [4:0] CFG_RESET = 5'h00;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } aib_state_type;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } aib_req_type;

    typedef struct packed {
        logic              done;
        logic              refused;
        logic [DATA_W-1:0] rdata;
    } aib_rsp_type;

endpackage

// [verif/aib_bridge_sva.sv]
// Assertion checker for the analog interface bus bridge
`timescale 1ns/1ns
`default_nettype none
module aib_bridge_sva
    import aib_pkg::*;
(
    input wire logic                       clock,
    input wire logic                       reset,
    input wire aib_req_type [NUM_REQ-1:0]  bus_req,
    input wire aib_rsp_type [NUM_REQ-1:0]  bus_rsp,
    input wire logic [NUM_TRIG-1:0]        master_eoc_irq,
    input wire logic [NUM_TRIG-1:0]        peripheral_interrupt_expander,
    input wire logic [NUM_DMA_TRIG-1:0]    control_dma_trigger
);
    logic [NUM_REQ-1:0] dn, rf, vl, hi_adr, rd_res;
    always_comb begin
        for (int i = 0; i < NUM_REQ; i++) begin
            dn[i]     = bus_rsp[i].done;
            rf[i]     = bus_rsp[i].refused;
            vl[i]     = bus_req[i].valid;
            hi_adr[i] = bus_req[i].addr >= 12'h020
                        && bus_req[i].addr != 12'h039;
            rd_res[i] = !bus_req[i].write && bus_req[i].addr < 12'h020;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_served; |dn; endsequence
    sequence s_quiet; dn == 4'h0; endsequence
    sequence s_irq_gone;
        (peripheral_interrupt_expander
            & $past(peripheral_interrupt_expander)) == 8'h00;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_one_grant: assert property ($onehot0(dn))
        else $error("two requesters answered at once");
    chk_done_needs_req: assert property ((dn & ~$past(vl)) == 4'h0)
        else $error("answer without a pending request");
    chk_done_spacing: assert property (s_served |=> s_quiet)
        else $error("answers closer than two cycles");
    chk_refused_done: assert property ((rf & ~dn) == 4'h0)
        else $error("refusal outside an answer");
    chk_ctl_cpu_only: assert property ((dn & hi_adr & 4'hb & ~rf) == 4'h0)
        else $error("non control CPU reached a control register");
    chk_result_open: assert property ((dn & rd_res & rf) == 4'h0)
        else $error("result read was refused");
    chk_pending_served: assert property ((vl & ~dn) != 4'h0
        |-> ##[1:8] s_served)
        else $error("pending request not served in time");
    chk_irq_mirror: assert property (master_eoc_irq
        == peripheral_interrupt_expander)
        else $error("interrupts differ between sides");
    chk_dma_subset: assert property (control_dma_trigger
        == peripheral_interrupt_expander[NUM_DMA_TRIG-1:0])
        else $error("DMA triggers differ from interrupts 0 to 3");
    chk_irq_pulse: assert property (peripheral_interrupt_expander != 8'h00
        |=> s_irq_gone)
        else $error("interrupt longer than one cycle");
endmodule
////////////////////////////////////////////////////////////////////////////
bind aib_bridge aib_bridge_sva i_aib_bridge_sva (
    .clock                         (clock),
    .reset                         (reset),
    .bus_req                       (bus_req),
    .bus_rsp                       (bus_rsp),
    .master_eoc_irq                (master_eoc_irq),
    .peripheral_interrupt_expander (peripheral_interrupt_expander),
    .control_dma_trigger           (control_dma_trigger)
);
`default_nettype wire

// [verif/aib_host_model.sv]
// Model of the four processor ports that drive the bridge
`timescale 1ns/1ns
`default_nettype none
module aib_host_model
    import aib_pkg::*;
(
    input  wire logic                      clock,
    output var aib_req_type [NUM_REQ-1:0]  bus_req,
    input  wire aib_rsp_type [NUM_REQ-1:0] bus_rsp
);
    initial bus_req = '0;
    // Port 2 is the control CPU bus, port 3 the control DMA bus
    task automatic access(input logic [1:0] r, input logic wr,
                          input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] wd,
                          output logic [DATA_W-1:0] rd, output logic rf);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        bus_req[r] = '{valid: 1'b1, write: wr, addr: a, wdata: wd};
        do begin
            @(posedge clock);
            n++;
        end while (bus_rsp[r].done !== 1'b1 && n < 50);
        rd = bus_rsp[r].rdata;
        rf = bus_rsp[r].refused;
        #1;
        // Released lines show the inverse, not the last value
        bus_req[r] = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~wd};
    endtask
endmodule
`default_nettype wire

// [verif/analog_interface_bus_bridge_tb.sv]
// Self-checking testbench of the analog interface bus bridge
`timescale 1ns/1ns
`default_nettype none
module analog_interface_bus_bridge_tb;
    import aib_pkg::*;
    logic clock = 0, reset = 1, powered = 1, aclk = 0, rf, sim, dn_ok;
    aib_req_type [NUM_REQ-1:0] bus_req;
    aib_rsp_type [NUM_REQ-1:0] bus_rsp;
    logic [NUM_SRC-1:0] soc = '0;
    logic [NUM_CHAN-1:0][RES_W-1:0] lev1 = '0, lev2 = '0;
    logic [NUM_TRIG-1:0] m_irq, p_irq;
    logic [NUM_DMA_TRIG-1:0] d_trig;
    logic [15:0] rd, e_last, ra[4];
    logic [11:0] alist[8] = '{12'h000, 12'h015, 12'h020, 12'h028,
                             12'h030, 12'h038, 12'h039, 12'h0ff};
    logic [31:0] seed = 32'h4a;
    logic [4:0] src;
    logic [3:0] ch, ch2;
    logic [2:0] k;
    logic rfa[4];
    int bad_count = 0, tests_run = 0, n;
    always #4 clock = ~clock;
    always #13 aclk = ~aclk;
    aib_bridge i_aib_bridge (.clock(clock), .reset(reset),
        .bus_req(bus_req), .bus_rsp(bus_rsp), .soc_source(soc),
        .first_converter_level(lev1), .second_converter_level(lev2),
        .analog_powered(powered), .analog_system_clock(aclk),
        .master_eoc_irq(m_irq), .peripheral_interrupt_expander(p_irq),
        .control_dma_trigger(d_trig));
    aib_host_model i_aib_host_model (.clock(clock), .bus_req(bus_req),
        .bus_rsp(bus_rsp));
    ////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic exp_ref(input logic [1:0] r, input logic wr,
                           input logic [11:0] a);
        if (a >= 12'h03a) return 1'b1;
        if (a < 12'h020) return wr;
        if (a == ADR_MSTR_STATUS) return wr || r != REQ_MASTER_CPU;
        return r != REQ_CONTROL_CPU || (wr && a == ADR_CTRL_STATUS);
    endfunction
    function logic [15:0] exp_res(input logic [NUM_CHAN-1:0][RES_W-1:0] lv,
                                  input logic [3:0] c, input logic s,
                                  input logic hi);
        return {4'h0, lv[s ? {hi, c[2:0]} : c]};
    endfunction
    task check_data(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task check_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task acc(input logic [1:0] r, input logic wr, input logic [11:0] a,
             input logic [15:0] wd);
        i_aib_host_model.access(r, wr, a, wd, rd, rf);
    endtask
    task summarize();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clock);
        #1 reset = 0;
        check_data({m_irq, p_irq}, 16'h0000);
        $display("test reset done");
        // Access rights for every requester, reads and writes
        for (int r = 0; r < 4; r++) begin
            for (int w = 0; w < 2; w++) begin
                foreach (alist[i]) begin
                    acc(r[1:0], w[0], alist[i],
                        alist[i] == ADR_TRIG_SEL ? 16'h001f : 16'h0000);
                    check_flag(rf, exp_ref(r[1:0], w[0], alist[i]));
                    if (w == 0 && (rf === 1'b1 || alist[i] >= 12'h020))
                        check_data(rd, exp_ref(r[1:0], 1'b0, alist[i]) ? 16'h0
                            : alist[i] == ADR_TRIG_SEL ? 16'h001f
                            : alist[i] == ADR_MSTR_STATUS ? 16'h1b
                            : alist[i] > 12'h37 ? 16'h1f : 16'h0);
                end
            end
        end
        $display("test access rights done");
        // Conversions with corner cases first, then random
        for (int it = 0; it < 10; it++) begin
            k = it == 0 ? 3'h0 : it == 1 ? 3'h7 : rnd() % 8;
            src = it == 1 ? 5'd21 : it == 0 ? 5'd0 : rnd() % 22;
            ch = rnd();
            ch2 = rnd();
            sim = it == 1 ? 1'b1 : rnd() % 2;
            for (int i = 0; i < 16; i++) begin
                lev1[i] = rnd();
                lev2[i] = rnd();
            end
            acc(2'h2, 1'b1, ADR_TRIG_SEL + k, {11'h0, src});
            acc(2'h2, 1'b1, ADR_CFG1_BASE + k, {11'h0, sim, ch});
            acc(2'h2, 1'b1, ADR_CFG2_BASE + k, {11'h0, sim, ch2});
            acc(2'h2, 1'b0, ADR_TRIG_SEL + k, 16'h0);
            check_data(rd, {11'h0, src});
            check_data({8'h00, p_irq}, 16'h0000);
            @(posedge clock);
            #1 soc[src] = 1'b1;
            @(posedge clock);
            #1 soc[src] = 1'b0;
            n = 0;
            while (p_irq[k] !== 1'b1 && n < 200) begin
                @(posedge clock);
                n++;
            end
            dn_ok = n >= 44 && n <= 60;
            check_flag(dn_ok, 1'b1);
            check_data({m_irq, p_irq}, {2{8'h01 << k}});
            check_data({12'h0, d_trig}, k < 4 ? 16'h0001 << k : 16'h0);
            // Results read only after the interrupt
            acc(rnd() % 4, 1'b0, ADR_RES1_BASE + k, 16'h0);
            check_data(rd, exp_res(lev1, ch, sim, 1'b0));
            acc(rnd() % 4, 1'b0, ADR_RES2_BASE + k, 16'h0);
            check_data(rd, exp_res(lev2, ch2, sim, 1'b0));
            if (sim) begin
                acc(2'h0, 1'b0, ADR_RES1_BASE + k + 8, 16'h0);
                check_data(rd, exp_res(lev1, ch, sim, 1'b1));
                acc(2'h3, 1'b0, ADR_RES2_BASE + k + 8, 16'h0);
                check_data(rd, exp_res(lev2, ch2, sim, 1'b1));
            end
            e_last = exp_res(lev1, ch, sim, 1'b0);
            acc(2'h2, 1'b1, ADR_TRIG_SEL + k, 16'h001f);
        end
        $display("test conversions done");
        // Four requesters pending at once
        fork
            i_aib_host_model.access(0, 0, k, 16'h0, ra[0], rfa[0]);
            i_aib_host_model.access(1, 0, k, 16'h0, ra[1], rfa[1]);
            i_aib_host_model.access(2, 0, k, 16'h0, ra[2], rfa[2]);
            i_aib_host_model.access(3, 0, k, 16'h0, ra[3], rfa[3]);
        join
        for (int i = 0; i < 4; i++) begin
            check_flag(rfa[i], 1'b0);
            check_data(ra[i], e_last);
        end
        $display("test arbitration done");
        // Status words, sticky refusal bit, power loss
        acc(2'h2, 1'b0, ADR_MSTR_STATUS, 16'h0);
        acc(2'h2, 1'b0, ADR_CTRL_STATUS, 16'h0);
        check_data(rd & 16'h0017, 16'h0013);
        acc(2'h2, 1'b0, ADR_CTRL_STATUS, 16'h0);
        check_data(rd & 16'h0017, 16'h0017);
        acc(2'h0, 1'b0, ADR_MSTR_STATUS, 16'h0);
        acc(2'h0, 1'b0, ADR_MSTR_STATUS, 16'h0);
        check_data(rd & 16'h0017, 16'h0017);
        powered = 1'b0;
        acc(2'h0, 1'b0, ADR_MSTR_STATUS, 16'h0);
        check_data(rd & 16'h0017, 16'h0006);
        $display("test status done");
        summarize();
    end
endmodule
`default_nettype wire
